// *** logic/crr_cmd_unit.sv ***
/*
  Request/reply command unit of a sensor node on a 29-bit identifier CAN bus.
  Takes received frames, decodes requests and addressed commands, starts the
  node's actions and builds one reply frame per answered request. Also turns
  attitude and rate samples into bus raw counts.
  Assumes a CAN controller that hands over whole frames with valid/ready,
  inputs synchronous to mclk, and a stable node address.
*/
// Notes on behaviour
// - request data names the wanted function
// - node only answers, never originates traffic
// - replies to global requests go to all
// - specific exchange: sender and addressed node only
// - version reply: five bytes, broadcast group
// - version bytes: major, minor, patch, stage, build
// - identification reply: eight bytes, broadcast group
// - algorithm reset restarts estimator, three-byte reply
// - reset reply extension configurable, default eighty
// - marker byte request/response, third byte success
// - second byte carries target node address
// - save request stores configuration in nonvolatile memory
// - hardware, software, status test replies
// - rate divider and packet type functions
// - low-pass filter setting function
// - mounting orientation change function
// - estimator acceleration parameter function
// - bank requests replace default extensions
// - angles: 1/32768 degree, offset minus 250
// - rates: 1/128 degree/s, offset minus 250
`timescale 1ns/1ps
`include "crr_defines.svh"

module crr_cmd_unit #(
  parameter int ANGLE_CH = 2,
  parameter int RATE_CH = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] node_addr,
  input crr_pkg::crr_version_t version,
  input wire logic [63:0] ecu_id,
  input wire logic [13:0] hw_bits,
  input wire logic [6:0] sw_bits,
  input wire logic [12:0] status_bits,
  input wire logic est_busy,
  input wire logic nv_busy,
  input wire logic rx_valid,
  input crr_pkg::crr_frame_t rx_frame,
  output logic rx_ready,
  output crr_pkg::crr_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic algo_reset_pulse,
  output logic save_cfg_pulse,
  output logic cfg_wr_pulse,
  output crr_pkg::crr_func_t cfg_func,
  output logic [47:0] cfg_data,
  input wire logic [ANGLE_CH-1:0][31:0] angle_in,
  input wire logic [RATE_CH-1:0][15:0] rate_in,
  output logic [ANGLE_CH-1:0][31:0] angle_raw,
  output logic [RATE_CH-1:0][15:0] rate_raw
);
  import crr_pkg::*;

  // ----------------------------------------------------------------------------
  // state and held frame
  // ----------------------------------------------------------------------------
  crr_state_t state_reg;
  crr_state_t state_next;
  crr_frame_t rx_hold_reg;
  crr_frame_t tx_frame_reg;
  crr_frame_t rep_frame;
  logic rep_want;
  logic [`CRR_PS_SLOTS-1:0][7:0] ps_table_reg;
  logic [`CRR_PS_SLOTS-1:0][7:0] ps_table_next;
  logic rx_ready_reg;
  logic tx_valid_reg;
  logic algo_reset_reg;
  logic save_cfg_reg;
  logic cfg_wr_reg;
  crr_func_t cfg_func_reg;
  logic [47:0] cfg_data_reg;
  logic [ANGLE_CH-1:0][31:0] angle_raw_reg;
  logic [RATE_CH-1:0][15:0] rate_raw_reg;
  crr_func_t dec_func;
  logic dec_global;

  // ----------------------------------------------------------------------------
  // decoding of the held frame
  // ----------------------------------------------------------------------------
  crr_req_decode u_decode (
    .frame(rx_hold_reg),
    .node_addr(node_addr),
    .ps_table(ps_table_reg),
    .func(dec_func),
    .is_global(dec_global)
  );

  // strobes of the phases
  wire take_rx = (state_reg == ST_IDLE) && rx_valid && rx_ready_reg; // no take before ready shows
  wire in_exec = (state_reg == ST_EXEC);
  wire sent = (state_reg == ST_SEND) && tx_ready;

  // action gating; a busy target is reported as failure
  wire arst_ok = !est_busy;
  wire save_ok = !nv_busy;
  wire do_arst = in_exec && (dec_func == FN_ALGO_RESET) && arst_ok;
  wire do_save = in_exec && (dec_func == FN_SAVE_CFG) && save_ok;
  wire is_cfg = (dec_func == FN_RATE_DIV) || (dec_func == FN_PKT_TYPE) || (dec_func == FN_FILTER)
    || (dec_func == FN_ORIENT) || (dec_func == FN_ACCEL);
  wire do_cfg = in_exec && is_cfg;
  wire do_bank0 = in_exec && (dec_func == FN_PS_BANK0);
  wire do_bank1 = in_exec && (dec_func == FN_PS_BANK1);
  wire [47:0] cmd_payload = rx_hold_reg.data[7:2];

  // reply bytes of the acknowledged commands
  wire [7:0] arst_result = arst_ok ? `CRR_BYTE_OK : `CRR_BYTE_FAIL;
  wire [7:0] save_result = save_ok ? `CRR_BYTE_OK : `CRR_BYTE_FAIL;
  wire [15:0] hw_word = {2'b00, hw_bits};
  wire [15:0] status_word = {3'b000, status_bits};

  // ----------------------------------------------------------------------------
  // reply identifier: priority six, broadcast group, own source
  // ----------------------------------------------------------------------------
  function automatic logic [28:0] crr_reply_id(input logic [7:0] pf, input logic [7:0] ps,
    input logic [7:0] sa);
    crr_reply_id = {`CRR_PRIO, 2'b00, pf, ps, sa};
  endfunction

  // reply frame per function; every reply is a broadcast group frame
  always_comb begin
    rep_frame = '0;
    rep_want = 1'b0;
    unique case (dec_func)
      FN_VERSION: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_VERSION, `CRR_PS_VERSION, node_addr);
        rep_frame.dlc = `CRR_LEN_VERSION;
        rep_frame.data[0] = version.major;
        rep_frame.data[1] = version.minor;
        rep_frame.data[2] = version.patch;
        rep_frame.data[3] = version.stage;
        rep_frame.data[4] = version.build;
      end
      FN_ECU_ID: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_ECU_ID, `CRR_PS_ECU_ID, node_addr);
        rep_frame.dlc = `CRR_LEN_ECU_ID;
        rep_frame.data = ecu_id;
      end
      FN_ALGO_RESET: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_PROP, ps_table_reg[`CRR_SLOT_ALGO_RESET], node_addr);
        rep_frame.dlc = `CRR_LEN_ACK;
        rep_frame.data[0] = `CRR_BYTE_RESPONSE;
        rep_frame.data[1] = node_addr;
        rep_frame.data[2] = arst_result;
      end
      FN_SAVE_CFG: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_PROP, ps_table_reg[`CRR_SLOT_SAVE_CFG], node_addr);
        rep_frame.dlc = `CRR_LEN_ACK;
        rep_frame.data[0] = `CRR_BYTE_RESPONSE;
        rep_frame.data[1] = node_addr;
        rep_frame.data[2] = save_result;
      end
      FN_TEST_HW: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_PROP, ps_table_reg[`CRR_SLOT_TEST_HW], node_addr);
        rep_frame.dlc = `CRR_LEN_TEST_HW;
        rep_frame.data[0] = hw_word[7:0];
        rep_frame.data[1] = hw_word[15:8];
      end
      FN_TEST_SW: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_PROP, ps_table_reg[`CRR_SLOT_TEST_SW], node_addr);
        rep_frame.dlc = `CRR_LEN_TEST_SW;
        rep_frame.data[0] = {1'b0, sw_bits};
      end
      FN_TEST_STATUS: begin
        rep_want = 1'b1;
        rep_frame.id = crr_reply_id(`CRR_PF_PROP, ps_table_reg[`CRR_SLOT_TEST_STATUS], node_addr);
        rep_frame.dlc = `CRR_LEN_STATUS;
        rep_frame.data[0] = status_word[7:0];
        rep_frame.data[1] = status_word[15:8];
      end
      FN_NONE, FN_RATE_DIV, FN_PKT_TYPE, FN_FILTER, FN_ORIENT, FN_ACCEL, FN_PS_BANK0, FN_PS_BANK1: begin
        rep_want = 1'b0;
      end
      default: begin
        rep_want = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // controller: take one frame, act, send at most one reply
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take_rx) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = rep_want ? ST_SEND : ST_IDLE;
      end
      ST_SEND: begin
        if (tx_ready) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // held request, loaded only when idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_hold_reg <= '0;
    end else if (take_rx) begin
      rx_hold_reg <= rx_frame;
    end
  end

  // handshake flags follow the next state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_ready_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
    end else begin
      rx_ready_reg <= (state_next == ST_IDLE);
      tx_valid_reg <= (state_next == ST_SEND);
    end
  end

  // reply frame, held until the controller takes it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_frame_reg <= '0;
    end else if (in_exec && rep_want) begin
      tx_frame_reg <= rep_frame;
    end
  end

  // ----------------------------------------------------------------------------
  // node actions
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      algo_reset_reg <= 1'b0;
      save_cfg_reg <= 1'b0;
      cfg_wr_reg <= 1'b0;
    end else begin
      algo_reset_reg <= do_arst;
      save_cfg_reg <= do_save;
      cfg_wr_reg <= do_cfg;
    end
  end

  // configuration function and its payload bytes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_func_reg <= FN_NONE;
      cfg_data_reg <= '0;
    end else if (do_cfg) begin
      cfg_func_reg <= dec_func;
      cfg_data_reg <= cmd_payload;
    end
  end

  // extension table, bank writes replace five slots each
  genvar gb;
  generate
    for (gb = 0; gb < `CRR_BANK_SLOTS; gb++) begin : g_bank
      assign ps_table_next[gb] = do_bank0 ? rx_hold_reg.data[gb + 2] : ps_table_reg[gb];
      assign ps_table_next[gb + `CRR_BANK_SLOTS] = do_bank1 ? rx_hold_reg.data[gb + 2]
        : ps_table_reg[gb + `CRR_BANK_SLOTS];
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ps_table_reg <= `CRR_PS_DEFAULTS;
    end else begin
      ps_table_reg <= ps_table_next;
    end
  end

  // ----------------------------------------------------------------------------
  // raw count conversion with saturation to the reported span
  // ----------------------------------------------------------------------------
  genvar ga;
  generate
    for (ga = 0; ga < ANGLE_CH; ga++) begin : g_angle
      wire signed [32:0] angle_sum = $signed({angle_in[ga][31], angle_in[ga]})
        + $signed(`CRR_ANGLE_OFFSET);
      wire angle_low = angle_sum[32];
      wire angle_high = !angle_sum[32] && (angle_sum > $signed(`CRR_ANGLE_MAX));
      wire [31:0] angle_sat = angle_low ? 32'h0000_0000
        : (angle_high ? 32'(`CRR_ANGLE_MAX) : angle_sum[31:0]);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          angle_raw_reg[ga] <= 32'h0000_0000;
        end else begin
          angle_raw_reg[ga] <= angle_sat;
        end
      end
    end
  endgenerate

  genvar gr;
  generate
    for (gr = 0; gr < RATE_CH; gr++) begin : g_rate
      wire signed [16:0] rate_sum = $signed({rate_in[gr][15], rate_in[gr]})
        + $signed(`CRR_RATE_OFFSET);
      wire rate_low = rate_sum[16];
      wire [15:0] rate_sat = rate_low ? 16'h0000 : rate_sum[15:0];
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          rate_raw_reg[gr] <= 16'h0000;
        end else begin
          rate_raw_reg[gr] <= rate_sat;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------------
  assign rx_ready = rx_ready_reg;
  assign tx_valid = tx_valid_reg;
  assign tx_frame = tx_frame_reg;
  assign algo_reset_pulse = algo_reset_reg;
  assign save_cfg_pulse = save_cfg_reg;
  assign cfg_wr_pulse = cfg_wr_reg;
  assign cfg_func = cfg_func_reg;
  assign cfg_data = cfg_data_reg;
  assign angle_raw = angle_raw_reg;
  assign rate_raw = rate_raw_reg;

endmodule

// *** logic/crr_defines.svh ***
/*
  Constants of the request/reply command unit: identifier fields, function
  numbers, default group extensions, payload values and scaling offsets.
  Assumes 29-bit extended identifiers laid out as priority, EDP, DP, PF, PS, SA.
*/
`ifndef CRR_DEFINES_SVH
`define CRR_DEFINES_SVH

// ----------------------------------------------------------------------------
// identifier fields
// ----------------------------------------------------------------------------
`define CRR_PRIO 3'h6
`define CRR_PF_REQUEST 8'hEA
`define CRR_PF_PROP 8'hFF
`define CRR_PF_VERSION 8'hFE
`define CRR_PS_VERSION 8'hDA
`define CRR_PF_ECU_ID 8'hFD
`define CRR_PS_ECU_ID 8'hC5
`define CRR_ADDR_GLOBAL 8'hFF
`define CRR_PS_BANK0 8'hF0
`define CRR_PS_BANK1 8'hF1

// ----------------------------------------------------------------------------
// function numbers carried in a request (page bits included)
// ----------------------------------------------------------------------------
`define CRR_PGN_REQUEST 18'h0EA00
`define CRR_PGN_VERSION 18'h0FEDA
`define CRR_PGN_ECU_ID 18'h0FDC5
`define CRR_PGN_ALGO_RESET 18'h0FF50
`define CRR_PGN_SAVE_CFG 18'h0FF51
`define CRR_PGN_TEST_HW 18'h0FF52
`define CRR_PGN_TEST_SW 18'h0FF53
`define CRR_PGN_TEST_STATUS 18'h0FF54
`define CRR_PGN_RATE_DIV 18'h0FF55
`define CRR_PGN_PKT_TYPE 18'h0FF56
`define CRR_PGN_FILTER 18'h0FF57
`define CRR_PGN_ORIENT 18'h0FF58
`define CRR_PGN_ACCEL 18'h0FF5D
`define CRR_PGN_PS_BANK0 18'h0FFF0
`define CRR_PGN_PS_BANK1 18'h0FFF1

// ----------------------------------------------------------------------------
// group extension table: slots 0..4 bank 0, slots 5..9 bank 1
// ----------------------------------------------------------------------------
`define CRR_PS_SLOTS 10
`define CRR_PS_DEFAULTS 80'h5D_58_57_56_55_54_53_52_51_50
`define CRR_SLOT_ALGO_RESET 0
`define CRR_SLOT_SAVE_CFG 1
`define CRR_SLOT_TEST_HW 2
`define CRR_SLOT_TEST_SW 3
`define CRR_SLOT_TEST_STATUS 4
`define CRR_SLOT_RATE_DIV 5
`define CRR_SLOT_PKT_TYPE 6
`define CRR_SLOT_FILTER 7
`define CRR_SLOT_ORIENT 8
`define CRR_SLOT_ACCEL 9
`define CRR_BANK_SLOTS 5

// ----------------------------------------------------------------------------
// payload lengths and values
// ----------------------------------------------------------------------------
`define CRR_LEN_REQUEST 4'h3
`define CRR_LEN_CMD 4'h3
`define CRR_LEN_BANK 4'h7
`define CRR_LEN_VERSION 4'h5
`define CRR_LEN_ECU_ID 4'h8
`define CRR_LEN_ACK 4'h3
`define CRR_LEN_TEST_HW 4'h8
`define CRR_LEN_TEST_SW 4'h1
`define CRR_LEN_STATUS 4'h2
`define CRR_BYTE_REQUEST 8'h00
`define CRR_BYTE_RESPONSE 8'h01
`define CRR_BYTE_FAIL 8'h00
`define CRR_BYTE_OK 8'h01

// ----------------------------------------------------------------------------
// engineering unit offsets
// ----------------------------------------------------------------------------
`define CRR_ANGLE_OFFSET 33'h0007D0000
`define CRR_ANGLE_MAX 33'h000FB0000
`define CRR_RATE_OFFSET 17'h07D00
`define CRR_RATE_MAX 17'h0FFFF

`endif

// *** logic/crr_pkg.sv ***
/*
  Types of the request/reply command unit: frame carrier, version record,
  function codes and controller states.
  Assumes crr_defines.svh supplies every numeric constant.
*/
package crr_pkg;

  // one CAN frame, byte i of the payload is data[i]
  typedef struct packed {
    logic [28:0] id;
    logic [3:0] dlc;
    logic [7:0][7:0] data;
  } crr_frame_t;

  // firmware version record, first byte first
  typedef struct packed {
    logic [7:0] major;
    logic [7:0] minor;
    logic [7:0] patch;
    logic [7:0] stage;
    logic [7:0] build;
  } crr_version_t;

  // decoded function of an accepted frame
  typedef enum logic [3:0] {
    FN_NONE, FN_VERSION, FN_ECU_ID, FN_ALGO_RESET, FN_SAVE_CFG, FN_TEST_HW, FN_TEST_SW,
    FN_TEST_STATUS, FN_RATE_DIV, FN_PKT_TYPE, FN_FILTER, FN_ORIENT, FN_ACCEL, FN_PS_BANK0,
    FN_PS_BANK1
  } crr_func_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SEND} crr_state_t;

endpackage

// *** logic/crr_req_decode.sv ***
/*
  Frame decoder of the request/reply command unit: classifies one held frame
  as a request or an addressed command and names the function it selects.
  Assumes the frame and the group extension table are stable while decoded.
*/
`timescale 1ns/1ps
`include "crr_defines.svh"

module crr_req_decode (
  input crr_pkg::crr_frame_t frame,
  input wire logic [7:0] node_addr,
  input wire logic [`CRR_PS_SLOTS-1:0][7:0] ps_table,
  output crr_pkg::crr_func_t func,
  output logic is_global
);
  import crr_pkg::*;

  // ----------------------------------------------------------------------------
  // identifier fields
  // ----------------------------------------------------------------------------
  wire [7:0] pf = frame.id[23:16];
  wire [7:0] ps = frame.id[15:8];
  wire page_ok = (frame.id[25:24] == 2'b00);
  wire [17:0] req_pgn = {frame.data[2][1:0], frame.data[1], frame.data[0]};

  // request frames, global or to this node only
  wire is_req = page_ok && (pf == `CRR_PF_REQUEST) && (frame.dlc >= `CRR_LEN_REQUEST);
  assign is_global = (ps == `CRR_ADDR_GLOBAL);
  wire req_to_me = is_req && (is_global || (ps == node_addr));

  // addressed commands carry request marker and target address
  wire is_cmd = page_ok && (pf == `CRR_PF_PROP) && (frame.dlc >= `CRR_LEN_CMD)
    && (frame.data[0] == `CRR_BYTE_REQUEST) && (frame.data[1] == node_addr);
  wire bank_len_ok = (frame.dlc >= `CRR_LEN_BANK);

  // ----------------------------------------------------------------------------
  // extension match per table slot
  // ----------------------------------------------------------------------------
  logic [`CRR_PS_SLOTS-1:0] slot_hit;
  genvar gi;
  generate
    for (gi = 0; gi < `CRR_PS_SLOTS; gi++) begin : g_slot
      assign slot_hit[gi] = (ps == ps_table[gi]);
    end
  endgenerate

  // function select, requests before commands
  always_comb begin
    func = FN_NONE;
    if (req_to_me) begin
      unique case (req_pgn)
        `CRR_PGN_VERSION: func = FN_VERSION;
        `CRR_PGN_ECU_ID: func = FN_ECU_ID;
        `CRR_PGN_SAVE_CFG: func = is_global ? FN_NONE : FN_SAVE_CFG;
        `CRR_PGN_TEST_HW: func = FN_TEST_HW;
        `CRR_PGN_TEST_SW: func = FN_TEST_SW;
        `CRR_PGN_TEST_STATUS: func = FN_TEST_STATUS;
        default: func = FN_NONE;
      endcase
    end else if (is_cmd) begin
      if (ps == `CRR_PS_BANK0) begin
        func = bank_len_ok ? FN_PS_BANK0 : FN_NONE;
      end else if (ps == `CRR_PS_BANK1) begin
        func = bank_len_ok ? FN_PS_BANK1 : FN_NONE;
      end else if (slot_hit[`CRR_SLOT_ALGO_RESET]) begin
        func = FN_ALGO_RESET;
      end else if (slot_hit[`CRR_SLOT_SAVE_CFG]) begin
        func = FN_SAVE_CFG;
      end else if (slot_hit[`CRR_SLOT_RATE_DIV]) begin
        func = FN_RATE_DIV;
      end else if (slot_hit[`CRR_SLOT_PKT_TYPE]) begin
        func = FN_PKT_TYPE;
      end else if (slot_hit[`CRR_SLOT_FILTER]) begin
        func = FN_FILTER;
      end else if (slot_hit[`CRR_SLOT_ORIENT]) begin
        func = FN_ORIENT;
      end else if (slot_hit[`CRR_SLOT_ACCEL]) begin
        func = FN_ACCEL;
      end
    end
  end

endmodule

// *** bench/crr_cmd_properties.sv ***
/*
  Checker of the command unit: reply framing and handshake relations.
  Assumes it is bound to crr_cmd_unit and sees only its ports.
*/
`timescale 1ns/1ps
module crr_cmd_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] node_addr,
  input crr_pkg::crr_version_t version,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input crr_pkg::crr_frame_t tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic algo_reset_pulse
);
  import crr_pkg::*;
  // ------------------------------------------------------------------------
  // reply relations
  // ------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take; rx_valid && rx_ready; endsequence
  sequence s_wait; tx_valid && !tx_ready; endsequence
  a_take_then_busy: assert property (s_take |=> !rx_ready)
    else $error("rx_ready high right after a take");
  a_reply_cause: assert property ($rose(tx_valid) |-> $past(rx_valid && rx_ready, 2))
    else $error("reply without a taken frame");
  a_reply_held: assert property (s_wait |=> tx_valid && $stable(tx_frame))
    else $error("reply dropped or changed before tx_ready");
  a_reply_id: assert property (tx_valid |-> tx_frame.id[28:26] == 3'h6 && tx_frame.id[7:0] == node_addr)
    else $error("reply priority or source wrong");
  a_version_frame: assert property (tx_valid && tx_frame.id[23:8] == 16'hFEDA |->
    tx_frame.dlc == 4'h5 && tx_frame.data[0] == version.major && tx_frame.data[4] == version.build)
    else $error("version reply wrong");
  a_ecu_len: assert property (tx_valid && tx_frame.id[23:8] == 16'hFDC5 |-> tx_frame.dlc == 4'h8)
    else $error("identification reply length wrong");
  a_reset_ack: assert property (algo_reset_pulse |-> tx_valid && tx_frame.data[0] == 8'h01 &&
    tx_frame.data[1] == node_addr && tx_frame.data[2] == 8'h01)
    else $error("reset reply bytes wrong");
  a_reset_pulse: assert property (algo_reset_pulse |=> !algo_reset_pulse)
    else $error("reset pulse longer than one cycle");
endmodule
bind crr_cmd_unit crr_cmd_props crr_cmd_props_inst (.mclk(mclk), .rst(rst), .node_addr(node_addr),
  .version(version), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_frame(tx_frame),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .algo_reset_pulse(algo_reset_pulse));

// *** bench/crr_host_sink.sv ***
/*
  Model of the bus controller taking reply frames, with a settable stall.
  Assumes valid/ready transfer on the rising edge of mclk.
*/
`timescale 1ns/1ps
module crr_host_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_valid,
  input crr_pkg::crr_frame_t tx_frame,
  input wire logic [3:0] stall,
  output logic tx_ready,
  output crr_pkg::crr_frame_t last,
  output int got
);
  logic [3:0] cnt;
  // ready after stall+1 valid cycles, frame kept on each take
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      cnt <= 4'h0;
      got <= 0;
    end else if (tx_valid && tx_ready) begin
      last <= tx_frame;
      got <= got + 1;
      tx_ready <= 1'b0;
      cnt <= 4'h0;
    end else if (tx_valid) begin
      cnt <= cnt + 4'h1;
      tx_ready <= (cnt >= stall);
    end
  end
endmodule

// *** bench/testbench.sv ***
/*
  Self-checking bench of the command unit: conversion cases, then table
  of requests, then busy, configuration and bank cases.
  Assumes the host sink model as far side.
*/
`timescale 1ns/1ps
module testbench;
  import crr_pkg::*;
  typedef struct packed {
    logic [7:0] pf, ps; logic [23:0] d; logic [7:0] epf, eps; logic [3:0] edlc; logic [63:0] ed;
  } crr_tb_row_t;
  logic mclk = 0, rst = 1, est_busy = 0, nv_busy = 0, rx_valid = 0;
  logic [6:0] sw = 7'h55;
  crr_frame_t rx_frame = '0, tx_frame, last;
  logic rx_ready, tx_valid, tx_ready, arp, scp, cwp;
  crr_func_t cfg_func;
  logic [47:0] cfg_data;
  logic [1:0][31:0] angle_in = {32'h00800000, 32'h0}, angle_raw;
  logic [2:0][15:0] rate_in = {16'h0100, 16'h8000, 16'h0}, rate_raw;
  logic [3:0] stall = 4'h0;
  int got, err_count = 0, total_checks = 0, rp = 0, sp = 0, cp = 0, n0;
  crr_tb_row_t r;
  crr_tb_row_t rows[11];
  always #4 mclk = ~mclk;
  crr_cmd_unit crr_cmd_unit_inst (.mclk(mclk), .rst(rst), .node_addr(8'h90),
    .version(40'h0102030405), .ecu_id(64'h8877665544332211), .hw_bits(14'h2A5B),
    .sw_bits(sw), .status_bits(13'h1ABC), .est_busy(est_busy), .nv_busy(nv_busy),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .tx_frame(tx_frame),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .algo_reset_pulse(arp), .save_cfg_pulse(scp),
    .cfg_wr_pulse(cwp), .cfg_func(cfg_func), .cfg_data(cfg_data), .angle_in(angle_in),
    .rate_in(rate_in), .angle_raw(angle_raw), .rate_raw(rate_raw));
  crr_host_sink crr_host_sink_inst (.mclk(mclk), .rst(rst), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .stall(stall), .tx_ready(tx_ready), .last(last), .got(got));
  // pulse counters
  always @(posedge mclk) begin
    rp <= rp + (arp === 1'b1);
    sp <= sp + (scp === 1'b1);
    cp <= cp + (cwp === 1'b1);
  end
  task automatic end_sim;
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(logic [63:0] g, logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // offer one frame from the host, held until taken
  task automatic send(logic [7:0] pf, logic [7:0] ps, logic [3:0] dlc, logic [63:0] d);
    int n;
    n = 0;
    n0 = got;
    rx_frame = '{{3'h6, 2'b00, pf, ps, 8'h81}, dlc, d};
    rx_valid = 1;
    while (rx_ready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    if (rx_ready !== 1'b1) begin
      err_count++;
      end_sim();
    end
    @(posedge mclk);
    #1 rx_valid = 0;
  endtask
  task automatic wait_rep(logic e);
    int n;
    n = 0;
    while (got == n0 && n < 12) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(got != n0, e);
  endtask
  initial begin
    rows = '{
      '{8'hEA, 8'hFF, 24'h0FEDA, 8'hFE, 8'hDA, 4'h5, 64'h0504030201},
      '{8'hEA, 8'hFF, 24'h0FDC5, 8'hFD, 8'hC5, 4'h8, 64'h8877665544332211},
      '{8'hEA, 8'h90, 24'h0FEDA, 8'hFE, 8'hDA, 4'h5, 64'h0504030201},
      '{8'hEA, 8'h91, 24'h0FEDA, 8'h00, 8'h00, 4'h0, 64'h0},
      '{8'hEB, 8'hFF, 24'h0FEDA, 8'h00, 8'h00, 4'h0, 64'h0},
      '{8'hEA, 8'hFF, 24'h0FF52, 8'hFF, 8'h52, 4'h8, 64'h2A5B},
      '{8'hEA, 8'h90, 24'h0FF53, 8'hFF, 8'h53, 4'h1, 64'h55},
      '{8'hEA, 8'h90, 24'h0FF54, 8'hFF, 8'h54, 4'h2, 64'h1ABC},
      '{8'hEA, 8'h90, 24'h0FF51, 8'hFF, 8'h51, 4'h3, 64'h019001},
      '{8'hFF, 8'h50, 24'h009000, 8'hFF, 8'h50, 4'h3, 64'h019001},
      '{8'hFF, 8'h50, 24'h009100, 8'h00, 8'h00, 4'h0, 64'h0}};
    repeat (6) @(posedge mclk);
    #1 chk({rx_ready, tx_valid}, 2'b00);
    rst = 0;
    repeat (2) @(posedge mclk);
    #1 chk({angle_raw[1], angle_raw[0]}, {32'hFB0000, 32'h7D0000});
    chk({rate_raw[2], rate_raw[1], rate_raw[0]}, {16'h7E00, 16'h0, 16'h7D00});
    // table of requests and commands
    foreach (rows[i]) begin
      r = rows[i];
      stall = i[3:0] % 4'h3;
      send(r.pf, r.ps, 4'h3, {40'h0, r.d});
      wait_rep(r.epf != 8'h00);
      if (r.epf != 8'h00) begin
        chk(last.id, {3'h6, 2'b00, r.epf, r.eps, 8'h90});
        chk(last.dlc, r.edlc);
        chk(last.data & ((64'h1 << (8 * r.edlc)) - 64'h1), r.ed);
      end
    end
    chk({rp, sp}, {32'd1, 32'd1});
    // busy targets report failure and fire no pulse
    est_busy = 1;
    send(8'hFF, 8'h50, 4'h3, 64'h009000);
    wait_rep(1);
    chk(last.data[2], 8'h00);
    est_busy = 0;
    nv_busy = 1;
    send(8'hEA, 8'h90, 4'h3, 64'h0FF51);
    wait_rep(1);
    chk(last.data[2], 8'h00);
    nv_busy = 0;
    chk({rp, sp}, {32'd1, 32'd1});
    // software test word follows its input
    sw = 7'h2A;
    send(8'hEA, 8'h90, 4'h3, 64'h0FF53);
    wait_rep(1);
    chk(last.data[0], 8'h2A);
    // configuration functions
    for (int i = 0; i < 5; i++) begin
      send(8'hFF, (i < 4) ? 8'h55 + i[7:0] : 8'h5D, 4'h8, {40'h0, 8'hA0 + i[7:0], 16'h9000});
      wait_rep(0);
      chk({cfg_func, cfg_data[7:0]}, {FN_RATE_DIV + i[3:0], 8'hA0 + i[7:0]});
    end
    chk(cp, 5);
    // bank 0 moves the reset extension
    send(8'hFF, 8'hF0, 4'h7, 64'h64636261609000);
    wait_rep(0);
    stall = 4'h5;
    send(8'hFF, 8'h60, 4'h3, 64'h009000);
    wait_rep(1);
    chk(last.id, {3'h6, 2'b00, 8'hFF, 8'h60, 8'h90});
    // reset in mid-run restores the default extensions
    rst = 1;
    @(posedge mclk);
    #1 rst = 0;
    send(8'hFF, 8'h50, 4'h3, 64'h009000);
    wait_rep(1);
    chk(last.id, {3'h6, 2'b00, 8'hFF, 8'h50, 8'h90});
    end_sim();
  end
endmodule
